//--- lfs_afe_model.sv
// Behavioural model of the analog front end that faces the fault supervisor.
`timescale 1ns/100ps
module lfs_afe_model (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Scenario controls from the bench.
  input wire logic [3:0] open_sel_in,
  input wire logic [3:0] short_sel_in,
  input wire logic ovp_force_in,
  // Supervisor output that drives the output voltage up.
  input wire logic vout_raise_in,
  // Comparator levels towards the supervisor.
  output logic ovp_out,
  output logic [3:0] open_out,
  output logic [3:0] short_out,
  output logic [3:0] inreg_out
);
  logic [1:0] raise_cnt_q; // Cycles the output has been rising.
  // ----------------------------------------------------------------------------
  // Output voltage climb
  // ----------------------------------------------------------------------------
  // A raised output reaches the overvoltage trip a few cycles later.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raise_cnt_q <= 2'h0;
    end else if (!vout_raise_in) begin
      raise_cnt_q <= 2'h0;
    end else if (raise_cnt_q != 2'h3) begin
      raise_cnt_q <= raise_cnt_q + 2'h1;
    end
  end
  assign ovp_out = ovp_force_in | (raise_cnt_q == 2'h3);
  // An open string never regulates; the others always do.
  assign open_out = open_sel_in;
  assign inreg_out = ~open_sel_in;
  assign short_out = short_sel_in;
endmodule // lfs_afe_model

//--- lfs_consts.svh
// Constants for the LED driver fault supervisor: counts, widths and reset values.
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing counts, in core clock cycles, and the counter width
// ----------------------------------------------------------------------------
`define LFS_SHDN_CYCLES 32750
`define LFS_SS_CYCLES 16
`define LFS_CNT_W 16

// ----------------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------------
`define LFS_STRINGS 4
`define LFS_SYNC_W 21
`define LFS_MASK_RST 4'h0

`endif

//--- lfs_pkg.sv
// Type package for the LED driver fault supervisor.
package lfs_pkg;

  // --------------------------------------------------------------------------
  // Supervisor states, Gray coded along off, start, run, search.
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LFS_OFF = 3'h0,
    LFS_START = 3'h1,
    LFS_RUN = 3'h3,
    LFS_SEARCH = 3'h2,
    LFS_LATCH = 3'h6
  } lfs_state_e;

endpackage

//--- lfs_supervisor.sv
// Fault-response supervisor for a four-string boost LED driver.
`timescale 1ns/100ps
`include "lfs_consts.svh"

// How it works
// - Shorted sink at startup holds soft-start off.
// - Open sink: raise output until overvoltage trips.
// - Then drop unregulated strings, return to regulation.
// - Current-set short: boost, sinks off, no flag.
// - Freq-set short: all off, flag, soft-start restart.
// - Overvoltage stops boost only, no flag.
// - Overtemperature: all off, no flag, auto restart.
// - Input undervoltage: all off, clear latched faults.
// - Secondary switch limit latches everything off, flag.
// - Input current 1x flags; 2x latches off.
module lfs_supervisor #(
  parameter int SHDN_CYCLES = `LFS_SHDN_CYCLES,
  parameter int SS_CYCLES = `LFS_SS_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Dimming/enable pin level.
  input wire logic enable_in,
  // Fault comparator levels from the analog front end.
  input wire logic uvlo_in,
  input wire logic sw_ilim2_in,
  input wire logic iin_lim1x_in,
  input wire logic iin_lim2x_in,
  input wire logic freq_set_sync_pin_short_in,
  input wire logic current_set_pin_short_in,
  input wire logic overtemp_in,
  input wire logic ovp_in,
  // Per-string sink pin indications.
  input wire logic [`LFS_STRINGS-1:0] led_sink_pin_short_in,
  input wire logic [`LFS_STRINGS-1:0] led_sink_pin_open_in,
  input wire logic [`LFS_STRINGS-1:0] led_sink_pin_inreg_in,
  // Power stage enables.
  output logic boost_en_out,
  output logic disc_sw_on_out,
  output logic [`LFS_STRINGS-1:0] sink_en_out,
  output logic softstart_out,
  output logic vout_raise_out,
  // Fault flag, high while a flagged fault stands.
  output logic fault_flag_out,
  // Supervisor state for observation.
  output lfs_pkg::lfs_state_e state_out
);
  import lfs_pkg::*;

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  logic [`LFS_SYNC_W-1:0] raw_w; // Bundle of asynchronous levels.
  logic [`LFS_SYNC_W-1:0] syn_w; // Same bundle, synchronised.
  assign raw_w = {enable_in, uvlo_in, sw_ilim2_in, iin_lim1x_in, iin_lim2x_in,
                  freq_set_sync_pin_short_in, current_set_pin_short_in, overtemp_in,
                  ovp_in, led_sink_pin_short_in, led_sink_pin_open_in,
                  led_sink_pin_inreg_in};

  // Every comparator passes two flops before use.
  lfs_sync #(.W(`LFS_SYNC_W)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(raw_w),
    .sync_out(syn_w)
  );

  logic en_s, uvlo_s, ilim2_s, lim1x_s, lim2x_s, fset_s, current_set_pin_s, otp_s, ovp_s;
  logic [`LFS_STRINGS-1:0] short_s, open_s, inreg_s; // Per-string levels.
  assign {en_s, uvlo_s, ilim2_s, lim1x_s, lim2x_s, fset_s, current_set_pin_s, otp_s, ovp_s,
          short_s, open_s, inreg_s} = syn_w;

  // --------------------------------------------------------------------------
  // State, counters and string mask
  // --------------------------------------------------------------------------
  lfs_state_e state_q, state_d; // Supervisor state.
  logic [`LFS_CNT_W-1:0] low_cnt_q; // Cycles the enable pin has been low.
  logic [`LFS_CNT_W-1:0] ss_cnt_q; // Soft-start progress.
  logic [`LFS_STRINGS-1:0] off_mask_q, off_mask_d; // Strings dropped as open.

  // Named decodes used by the state logic.
  wire latch_hit_w = ilim2_s | lim2x_s;
  wire restart_hit_w = fset_s | otp_s;
  wire shdn_w = (low_cnt_q == `LFS_CNT_W'(SHDN_CYCLES));
  wire ss_done_w = (ss_cnt_q == `LFS_CNT_W'(SS_CYCLES));
  wire led_short_w = |short_s;
  wire open_seen_w = |(open_s & ~off_mask_q);

  // Counts enable-low cycles, saturating at the shutdown count.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_q <= '0;
    end else if (en_s) begin
      low_cnt_q <= '0;
    end else if (!shdn_w) begin
      low_cnt_q <= low_cnt_q + `LFS_CNT_W'(1);
    end
  end

  // Soft-start counter runs only in start while no sink short is seen.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ss_cnt_q <= '0;
    end else if (state_q != LFS_START || restart_hit_w) begin
      ss_cnt_q <= '0; // A restart fault rewinds soft-start so it runs in full.
    end else if (!led_short_w && !ss_done_w) begin
      ss_cnt_q <= ss_cnt_q + `LFS_CNT_W'(1);
    end
  end

  // Next state: undervoltage first, then latching faults, then the rest.
  always_comb begin
    state_d = state_q;
    off_mask_d = off_mask_q;
    if (uvlo_s) begin
      state_d = LFS_OFF; // Clears any latched fault.
      off_mask_d = `LFS_MASK_RST;
    end else if (latch_hit_w) begin
      state_d = LFS_LATCH;
    end else begin
      case (state_q)
        LFS_OFF: begin
          if (en_s) begin
            state_d = LFS_START;
          end
        end
        LFS_START: begin
          if (shdn_w) begin
            state_d = LFS_OFF;
          end else if (restart_hit_w) begin
            state_d = LFS_START;
          end else if (ss_done_w) begin
            state_d = LFS_RUN;
          end
        end
        LFS_RUN: begin
          if (shdn_w) begin
            state_d = LFS_OFF;
          end else if (restart_hit_w) begin
            state_d = LFS_START; // Auto restart via soft-start.
          end else if (open_seen_w) begin
            state_d = LFS_SEARCH;
          end
        end
        LFS_SEARCH: begin
          if (shdn_w) begin
            state_d = LFS_OFF;
          end else if (restart_hit_w) begin
            state_d = LFS_START;
          end else if (ovp_s) begin
            off_mask_d = off_mask_q | ~inreg_s;
            state_d = LFS_RUN;
          end
        end
        LFS_LATCH: begin
          if (shdn_w) begin
            state_d = LFS_OFF; // Long enable-low releases the latch.
          end
        end
        default: begin
          state_d = LFS_OFF;
        end
      endcase
      if (state_d == LFS_OFF) begin
        off_mask_d = `LFS_MASK_RST;
      end
    end
  end

  // State and mask registers.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= LFS_OFF;
      off_mask_q <= `LFS_MASK_RST;
    end else begin
      state_q <= state_d;
      off_mask_q <= off_mask_d;
    end
  end

  // --------------------------------------------------------------------------
  // Output decode
  // --------------------------------------------------------------------------
  wire active_w = (state_q == LFS_RUN) || (state_q == LFS_SEARCH);
  wire hard_off_w = uvlo_s | latch_hit_w | restart_hit_w;
  wire start_hold_w = (state_q == LFS_START) && led_short_w;

  logic boost_d, disc_d, ss_d, raise_d, flag_d;
  logic [`LFS_STRINGS-1:0] sink_d;
  assign boost_d = !hard_off_w && !current_set_pin_s && !ovp_s && !start_hold_w
                   && (active_w || state_q == LFS_START);
  assign disc_d = !hard_off_w && (state_q != LFS_OFF) && (state_q != LFS_LATCH);
  assign sink_d = (!hard_off_w && !current_set_pin_s && active_w) ? ~off_mask_q : '0;
  assign ss_d = !hard_off_w && (state_q == LFS_START) && !led_short_w;
  assign raise_d = boost_d && (state_q == LFS_SEARCH);
  assign flag_d = !uvlo_s && (latch_hit_w || fset_s || lim1x_s
                  || state_q == LFS_LATCH);

  // Output registers, so every enable changes only on a clock edge.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boost_en_out <= 1'b0;
      disc_sw_on_out <= 1'b0;
      sink_en_out <= '0;
      softstart_out <= 1'b0;
      vout_raise_out <= 1'b0;
      fault_flag_out <= 1'b0;
    end else begin
      boost_en_out <= boost_d;
      disc_sw_on_out <= disc_d;
      sink_en_out <= sink_d;
      softstart_out <= ss_d;
      vout_raise_out <= raise_d;
      fault_flag_out <= flag_d;
    end
  end

  assign state_out = state_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_SHORT_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_q == LFS_START && led_short_w && !hard_off_w) |=> (!boost_en_out
      && sink_en_out == '0 && disc_sw_on_out && !softstart_out && !fault_flag_out))
    else $error("Sink short at startup not held.");
  AST_SEARCH_RAISE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_q == LFS_RUN && open_seen_w && !hard_off_w && !shdn_w && !lim1x_s)
      |=> (state_q == LFS_SEARCH) ##0 !fault_flag_out)
    else $error("Open sink did not start the search.");
  AST_DROP_OPEN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_q == LFS_SEARCH && ovp_s && !hard_off_w && !shdn_w)
      |=> (state_q == LFS_RUN && (off_mask_q & ~$past(inreg_s)) == ~$past(inreg_s)))
    else $error("Unregulated strings not dropped.");
  AST_CURRENT_SET_PIN_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (current_set_pin_s && !hard_off_w) |=> (!boost_en_out && sink_en_out == '0))
    else $error("Current-set short left boost or sinks on.");
  AST_FSET_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (fset_s && !uvlo_s) |=> (!boost_en_out && !disc_sw_on_out && fault_flag_out))
    else $error("Freq-set short response wrong.");
  AST_OVP_BOOST: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (ovp_s && state_q == LFS_RUN && !hard_off_w && !current_set_pin_s)
      |=> (!boost_en_out && disc_sw_on_out && sink_en_out == ~$past(off_mask_q)))
    else $error("Overvoltage response wrong.");
  AST_OTP_OFF: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (otp_s && !fset_s && !latch_hit_w && !lim1x_s && state_q != LFS_LATCH)
      |=> (!boost_en_out && !disc_sw_on_out && sink_en_out == '0 && !fault_flag_out))
    else $error("Overtemperature response wrong.");
  AST_UVLO_CLEAR: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    uvlo_s |=> (state_q == LFS_OFF && !boost_en_out && !disc_sw_on_out && !fault_flag_out))
    else $error("Undervoltage did not clear and shut off.");
  AST_LATCH_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_q == LFS_LATCH && !uvlo_s && !shdn_w) |=> (state_q == LFS_LATCH && fault_flag_out
      && !disc_sw_on_out && !boost_en_out && sink_en_out == '0))
    else $error("Latched fault released early.");
  AST_LATCH_ENTRY: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (latch_hit_w && !uvlo_s) |=> (state_q == LFS_LATCH && fault_flag_out
      && sink_en_out == '0))
    else $error("Latching fault not latched.");
  AST_REENABLE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_q == LFS_LATCH && shdn_w && !uvlo_s && !latch_hit_w) |=> state_q == LFS_OFF)
    else $error("Long enable-low did not release latch.");

endmodule // lfs_supervisor

//--- lfs_supervisor_bench.sv
// Self-checking bench for the LED driver fault supervisor.
`timescale 1ns/100ps
module lfs_supervisor_bench;
  import lfs_pkg::*;
  localparam int SHDN = 20; // Shortened enable-low shutdown count.
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic uvlo_in = 1'b0;
  logic ilim2 = 1'b0;
  logic lim1x = 1'b0;
  logic lim2x = 1'b0;
  logic fset = 1'b0;
  logic current_set_pin = 1'b0;
  logic otp = 1'b0;
  logic ovp_force = 1'b0;
  logic [3:0] open_sel = 4'h0;
  logic [3:0] short_sel = 4'h0;
  logic ovp;
  logic vraise;
  logic [3:0] open_w, short_w, inreg_w, sink;
  logic boost, disc, ss, flag;
  lfs_state_e state;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  always #25 core_clk_in = ~core_clk_in;
  lfs_supervisor #(.SHDN_CYCLES(SHDN), .SS_CYCLES(4)) dut (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .enable_in(enable_in), .uvlo_in(uvlo_in), .sw_ilim2_in(ilim2),
    .iin_lim1x_in(lim1x), .iin_lim2x_in(lim2x), .freq_set_sync_pin_short_in(fset),
    .current_set_pin_short_in(current_set_pin), .overtemp_in(otp), .ovp_in(ovp),
    .led_sink_pin_short_in(short_w), .led_sink_pin_open_in(open_w),
    .led_sink_pin_inreg_in(inreg_w), .boost_en_out(boost), .disc_sw_on_out(disc),
    .sink_en_out(sink), .softstart_out(ss), .vout_raise_out(vraise),
    .fault_flag_out(flag), .state_out(state));
  lfs_afe_model afe (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .open_sel_in(open_sel),
    .short_sel_in(short_sel), .ovp_force_in(ovp_force), .vout_raise_in(vraise),
    .ovp_out(ovp), .open_out(open_w), .short_out(short_w), .inreg_out(inreg_w));
  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits n falling edges, where the bench drives.
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Packs boost, disconnect, sinks and flag as bits 6, 5, 4:1 and 0.
  task automatic outs(input string what, input logic [7:0] exp);
    chk(what, {1'b0, boost, disc, sink, flag}, exp);
  endtask
  // Waits a bounded time for a state, then checks it.
  task automatic wait_state(input lfs_state_e s, input int bound);
    for (int i = 0; i < bound && state !== s; i++) cyc(1);
    chk("state", {5'h00, state}, {5'h00, s});
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // A shorted sink holds soft-start off until it clears.
  task automatic t_start();
    short_sel = 4'h4;
    enable_in = 1'b1;
    cyc(12);
    outs("short hold", 8'h20);
    chk("softstart", {7'h00, ss}, 8'h00);
    short_sel = 4'h0;
    wait_state(LFS_RUN, 40);
    cyc(2);
    outs("run", 8'h7E);
    $display("test start done");
  endtask
  // Current-set short and overvoltage each act for their span only.
  task automatic t_current_set_pin_ovp();
    current_set_pin = 1'b1;
    cyc(4);
    outs("current_set_pin", 8'h20);
    current_set_pin = 1'b0;
    ovp_force = 1'b1;
    cyc(4);
    outs("ovp", 8'h3E);
    ovp_force = 1'b0;
    cyc(4);
    outs("ovp gone", 8'h7E);
    $display("test current_set_pin and ovp done");
  endtask
  // Frequency-set short and overtemperature restart through soft-start.
  task automatic t_restart();
    for (int k = 0; k < 2; k++) begin
      fset = (k == 0);
      otp = (k == 1);
      cyc(4);
      outs("restart off", {7'h00, fset});
      fset = 1'b0;
      otp = 1'b0;
      wait_state(LFS_START, 10);
      cyc(4);
      chk("restart softstart", {7'h00, ss}, 8'h01);
      wait_state(LFS_RUN, 40);
      cyc(2);
      outs("restarted", 8'h7E);
    end
    lim1x = 1'b1;
    cyc(4);
    outs("1x flag", 8'h7F);
    lim1x = 1'b0;
    cyc(4);
    outs("1x gone", 8'h7E);
    $display("test restart done");
  endtask
  // An open string is found by raising the output, then dropped.
  task automatic t_open();
    open_sel = 4'h2;
    wait_state(LFS_SEARCH, 10);
    cyc(1); // The raise output is registered one edge after the state.
    chk("raise", {6'h00, vraise, flag}, 8'h02);
    wait_state(LFS_RUN, 20);
    cyc(6);
    outs("dropped", 8'h7A);
    chk("raise off", {7'h00, vraise}, 8'h00);
    open_sel = 4'h0;
    $display("test open done");
  endtask
  // Secondary switch limit and 2x input current latch until enable stays low for the shutdown count.
  task automatic t_latch();
    for (int k = 0; k < 2; k++) begin
      ilim2 = (k == 0);
      lim2x = (k == 1);
      cyc(4);
      ilim2 = 1'b0;
      lim2x = 1'b0;
      cyc(6);
      chk("latched", {5'h00, state}, {5'h00, LFS_LATCH});
      outs("latched", 8'h01);
      enable_in = 1'b0;
      cyc(SHDN + 8);
      chk("shutdown", {5'h00, state}, {5'h00, LFS_OFF});
      enable_in = 1'b1;
      wait_state(LFS_RUN, 40);
      cyc(2);
      outs("relatched run", 8'h7E);
    end
    $display("test latch done");
  endtask
  // Undervoltage turns all off and clears a latched fault.
  task automatic t_uvlo();
    ilim2 = 1'b1;
    cyc(4);
    ilim2 = 1'b0;
    uvlo_in = 1'b1;
    cyc(6);
    outs("uvlo", 8'h00);
    chk("uvlo state", {5'h00, state}, {5'h00, LFS_OFF});
    uvlo_in = 1'b0;
    wait_state(LFS_RUN, 40);
    $display("test uvlo done");
  endtask
  // ----------------------------------------------------------------------------
  // Closing report and sequence
  // ----------------------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    cyc(5);
    rst_n_in = 1'b1;
    t_start();
    t_current_set_pin_ovp();
    t_restart();
    t_open();
    t_latch();
    t_uvlo();
    print_verdict();
  end
endmodule // lfs_supervisor_bench

//--- lfs_sync.sv
// Two flip-flop synchroniser for a bundle of level inputs.
`timescale 1ns/100ps
module lfs_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q; // First stage, read only by the second stage.

  // Two stages; the first is never looked at by logic.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // lfs_sync
